// file: dv/sps_cpu_model.sv
// cpu sequencer model: one-cycle service and return pulses.
// assumes callers enter its tasks outside any other drive of its lines.
`timescale 1ns/1ns
`default_nettype none
module sps_cpu_model (
	input  wire logic  clk,
	output logic       svc,
	output logic [7:0] page,
	output logic       ret
);
	initial begin
		svc = 1'b0;
		ret = 1'b0;
		page = 8'ha5;
	end
	// page inverted after the pulse so a stale value is never read as valid
	task automatic service(input logic [7:0] p);
		@(posedge clk);
		svc <= 1'b1;
		page <= p;
		@(posedge clk);
		svc <= 1'b0;
		page <= ~p;
	endtask
	task automatic give_return;
		@(posedge clk);
		ret <= 1'b1;
		@(posedge clk);
		ret <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: dv/sps_page_stack_asserts.sv
// checker for the page-context stack: page moves and bus handshakes.
// assumes it is bound to sps_page_stack and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module sps_page_stack_asserts (
	input wire logic        CLK,
	input wire logic        RESET,
	input wire logic        INT_SERVICE,
	input wire logic [7:0]  INT_PAGE,
	input wire logic        INT_RETURN,
	input wire logic [7:0]  ACTIVE_PAGE_SELECT,
	input wire logic        AUTO_PAGE_ENABLE,
	input wire logic        S_AXI_AWVALID,
	input wire logic        S_AXI_AWREADY,
	input wire logic        S_AXI_WVALID,
	input wire logic        S_AXI_WREADY,
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_BREADY,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_ARREADY,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);

	// a write is idle when both readys are up and no response is pending
	property p_push;
		INT_SERVICE && AUTO_PAGE_ENABLE |=> ACTIVE_PAGE_SELECT == $past(INT_PAGE);
	endproperty
	a_push: assert property (p_push) else $error("service did not load page");
	property p_off;
		!AUTO_PAGE_ENABLE && (INT_SERVICE || INT_RETURN) && S_AXI_AWREADY && S_AXI_WREADY
			&& !S_AXI_BVALID |=> $stable(ACTIVE_PAGE_SELECT);
	endproperty
	a_off: assert property (p_off) else $error("page moved while disabled");
	property p_cause;
		$changed(ACTIVE_PAGE_SELECT) |-> $past(INT_SERVICE) || $past(INT_RETURN)
			|| S_AXI_BVALID || $past(S_AXI_BVALID);
	endproperty
	a_cause: assert property (p_cause) else $error("page changed with no cause");
	property p_auto;
		$changed(AUTO_PAGE_ENABLE) |-> S_AXI_BVALID || $past(S_AXI_BVALID);
	endproperty
	a_auto: assert property (p_auto) else $error("enable changed with no write");
	property p_wlat;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
			|=> !S_AXI_AWREADY ##1 S_AXI_BVALID;
	endproperty
	a_wlat: assert property (p_wlat) else $error("write response late");
	property p_bdone;
		S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
	endproperty
	a_bdone: assert property (p_bdone) else $error("write response repeated");
	property p_rlat;
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
	endproperty
	a_rlat: assert property (p_rlat) else $error("read data late");
	property p_rdone;
		S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
	endproperty
	a_rdone: assert property (p_rdone) else $error("read data repeated");
	property p_rhi;
		S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0;
	endproperty
	a_rhi: assert property (p_rhi) else $error("read upper bits not zero");
	c_push: cover property (INT_SERVICE && AUTO_PAGE_ENABLE);
	c_pop: cover property (INT_RETURN && AUTO_PAGE_ENABLE);
	c_off: cover property (INT_SERVICE && !AUTO_PAGE_ENABLE);
endmodule
bind sps_page_stack sps_page_stack_asserts u_chk (.CLK, .RESET, .INT_SERVICE, .INT_PAGE,
	.INT_RETURN, .ACTIVE_PAGE_SELECT, .AUTO_PAGE_ENABLE, .S_AXI_AWVALID, .S_AXI_AWREADY,
	.S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
	.S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA);
`default_nettype wire

// file: dv/sps_page_stack_tb.sv
// self-checking bench for the page-context stack over axi4-lite.
// assumes the cpu model and the bound checker sit beside the design.
`timescale 1ns/1ns
`default_nettype none
module sps_page_stack_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	wire logic   awready, wready, bvalid, arready, rvalid, svc, ret, aen;
	wire logic [1:0]  bresp, rresp;
	wire logic [7:0]  pg, act;
	wire logic [31:0] rdata;
	logic [31:0] d;
	logic [1:0]  r;
	int          s[3];
	int          en;
	int          n_push = 0;
	int          n_pop = 0;
	int          n_mismatch = 0;
	int          check_count = 0;
	int          cyc = 0;
	integer      seed = 32'ha98c99f0;

	always #10 clk = ~clk;

	sps_page_stack u_dut (.CLK(clk), .RESET(rst), .INT_SERVICE(svc), .INT_PAGE(pg),
		.INT_RETURN(ret), .ACTIVE_PAGE_SELECT(act), .AUTO_PAGE_ENABLE(aen),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	sps_cpu_model u_cpu (.clk(clk), .svc(svc), .page(pg), .ret(ret));

	// hang guard: the whole run needs well under this many cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			n_mismatch++;
			results();
		end
	end

	task automatic results;
		if (n_mismatch == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask

	// upper data bits are random to show they are ignored
	task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] st);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'($random(seed)), v};
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// reference stack: s[0] active page, s[1] middle, s[2] bottom
	task automatic push(input logic [7:0] p);
		u_cpu.service(p);
		if (en) begin
			n_push++;
			s[2] = s[1];
			s[1] = s[0];
			s[0] = p;
		end
	endtask
	task automatic pop;
		u_cpu.give_return();
		if (en) begin
			n_pop++;
			s[0] = s[1];
			s[1] = s[2];
			s[2] = 0;
		end
	endtask
	task automatic put(input int k, input logic [7:0] v);
		wr(sps_pkg::ADDR_ACTIVE + 12'(4 * k), v, 4'h1);
		cmp("entry_bresp", 32'(sps_pkg::RESP_OKAY), 32'(r));
		s[k] = v;
	endtask
	task automatic chk;
		for (int k = 0; k < 3; k++) begin
			rd(sps_pkg::ADDR_ACTIVE + 12'(4 * k));
			cmp("entry", 32'(s[k]), d);
			cmp("entry_rresp", 32'(sps_pkg::RESP_OKAY), 32'(r));
		end
		cmp("active_port", 32'(s[0]), 32'(act));
	endtask

	initial begin
		s = '{0, 0, 0};
		en = 1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(sps_pkg::ADDR_CONTROL);
		cmp("auto_en", 32'h1, d);
		chk;
		put(0, 8'h0f);
		push(8'h02);
		chk;
		put(2, 8'h55);
		chk;
		push(8'h00);
		chk;
		pop;
		chk;
		put(1, 8'h33);
		pop;
		chk;
		wr(sps_pkg::ADDR_MIDDLE, 8'h44, 4'h0);
		cmp("nostrb_bresp", 32'(sps_pkg::RESP_OKAY), 32'(r));
		chk;
		wr(12'h100, 8'h11, 4'h1);
		cmp("bad_bresp", 32'(sps_pkg::RESP_SLVERR), 32'(r));
		rd(12'h100);
		cmp("bad_rdata", 32'h0, d);
		cmp("bad_rresp", 32'(sps_pkg::RESP_SLVERR), 32'(r));
		wr(sps_pkg::ADDR_CONTROL, 8'h00, 4'h1);
		en = 0;
		push(8'h07);
		cmp("auto_port", 32'h0, 32'(aen));
		pop;
		chk;
		wr(sps_pkg::ADDR_CONTROL, 8'h01, 4'h1);
		en = 1;
		for (int i = 0; i < 30; i++) begin
			case (2'($random(seed)))
				2'h0: push(8'($random(seed)));
				2'h1: pop;
				default: put($unsigned($random(seed)) % 3, 8'($random(seed)));
			endcase
			chk;
		end
		// event counts show that only enabled service and return moved the stack
		rd(sps_pkg::ADDR_EVENTS);
		cmp("events", {16'h0000, 8'(n_pop), 8'(n_push)}, d);
		results();
	end
endmodule
`default_nettype wire

// file: verilog/sps_hold_slot.sv
// one-entry holding slot for an axi-lite request channel.
// assumes the consumer pulses consume only while the slot is full.
`timescale 1ns/1ns
`default_nettype none
module sps_hold_slot #(
	parameter int W = 32
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              held_valid,
	output logic [W-1:0]      held_data,
	input  wire logic         consume
);
	typedef struct packed {
		logic         ready;
		logic [W-1:0] data;
	} sps_slot_t;

	sps_slot_t s_reg;
	sps_slot_t s_next;

	// ready is kept as the flop so the bus sees it without logic in between
	always_comb begin
		s_next = s_reg;
		if (s_reg.ready && in_valid) begin
			s_next.ready = 1'b0;
			s_next.data  = in_data;
		end else if (!s_reg.ready && consume) begin
			s_next.ready = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_reg <= '{ready: 1'b1, data: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign in_ready   = s_reg.ready;
	assign held_valid = !s_reg.ready;
	assign held_data  = s_reg.data;
endmodule
`default_nettype wire

// file: verilog/sps_page_stack.sv
// page-context stack with its axi4-lite register slave.
// assumes the cpu core gives one-cycle service and return pulses on CLK,
// with the page of the interrupting source beside the service pulse.
`timescale 1ns/1ns
`default_nettype none
module sps_page_stack (
	input  wire logic        CLK,
	input  wire logic        RESET,
	// cpu sequencer
	input  wire logic        INT_SERVICE,
	input  wire logic [7:0]  INT_PAGE,
	input  wire logic        INT_RETURN,
	output logic [7:0]       ACTIVE_PAGE_SELECT,
	output logic             AUTO_PAGE_ENABLE,
	// axi4-lite slave
	input  wire logic [11:0] S_AXI_AWADDR,
	input  wire logic [2:0]  S_AXI_AWPROT,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [11:0] S_AXI_ARADDR,
	input  wire logic [2:0]  S_AXI_ARPROT,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY
);
	typedef struct packed {
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic        auto_en;
		logic        wr_top;
		logic        wr_mid;
		logic        wr_bot;
		logic [7:0]  wr_data;
		logic [7:0]  push_cnt;
		logic [7:0]  pop_cnt;
	} sps_top_t;

	sps_top_t s_reg;
	sps_top_t s_next;

	logic        aw_held;
	logic [11:0] aw_addr;
	logic        w_held;
	logic [35:0] w_word;
	logic        wr_consume;
	logic [7:0]  page_top;
	logic [7:0]  page_mid;
	logic [7:0]  page_bot;
	logic        push_ok;
	logic        pop_ok;

	// protection bits carry nothing for this block
	logic        prot_unused;
	assign prot_unused = ^{S_AXI_AWPROT, S_AXI_ARPROT};

	// write address and data are caught independently, in either order
	sps_hold_slot #(
		.W(12)
	) u_aw_slot (
		.clk        (CLK),
		.reset      (RESET),
		.in_valid   (S_AXI_AWVALID),
		.in_data    (S_AXI_AWADDR),
		.in_ready   (S_AXI_AWREADY),
		.held_valid (aw_held),
		.held_data  (aw_addr),
		.consume    (wr_consume)
	);

	sps_hold_slot #(
		.W(36)
	) u_w_slot (
		.clk        (CLK),
		.reset      (RESET),
		.in_valid   (S_AXI_WVALID),
		.in_data    ({S_AXI_WSTRB, S_AXI_WDATA}),
		.in_ready   (S_AXI_WREADY),
		.held_valid (w_held),
		.held_data  (w_word),
		.consume    (wr_consume)
	);

	// only cpu pulses move the stack, and only when enabled
	assign push_ok = s_reg.auto_en && INT_SERVICE;
	assign pop_ok  = s_reg.auto_en && INT_RETURN && !INT_SERVICE;

	// the three entries live together in one core
	sps_stack_core u_core (
		.clk       (CLK),
		.reset     (RESET),
		.auto_en   (s_reg.auto_en),
		.push      (INT_SERVICE),
		.push_page (INT_PAGE),
		.pop       (INT_RETURN),
		.wr_top    (s_reg.wr_top),
		.wr_mid    (s_reg.wr_mid),
		.wr_bot    (s_reg.wr_bot),
		.wr_data   (s_reg.wr_data),
		.top_q     (page_top),
		.mid_q     (page_mid),
		.bot_q     (page_bot)
	);

	// word-aligned match of a byte address against a register address
	function automatic logic addr_hit(
		input logic [11:0] addr,
		input logic [11:0] reg_addr
	);
		addr_hit = (addr[11:2] == reg_addr[11:2]);
	endfunction

	// read data for a register address; unmapped reads give zero
	function automatic logic [31:0] read_word(
		input logic [11:0] addr,
		input logic [7:0]  top,
		input logic [7:0]  mid,
		input logic [7:0]  bot,
		input logic        en,
		input logic [7:0]  pushes,
		input logic [7:0]  pops
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (addr_hit(addr, sps_pkg::ADDR_ACTIVE)) begin
			w[7:0] = top;
		end else if (addr_hit(addr, sps_pkg::ADDR_MIDDLE)) begin
			w[7:0] = mid;
		end else if (addr_hit(addr, sps_pkg::ADDR_BOTTOM)) begin
			w[7:0] = bot;
		end else if (addr_hit(addr, sps_pkg::ADDR_CONTROL)) begin
			w[sps_pkg::CTRL_AUTO_BIT] = en;
		end else if (addr_hit(addr, sps_pkg::ADDR_EVENTS)) begin
			w[sps_pkg::EVT_PUSH_LSB +: 8] = pushes;
			w[sps_pkg::EVT_POP_LSB +: 8]  = pops;
		end
		read_word = w;
	endfunction

	// is the address one of the mapped registers
	function automatic logic mapped(
		input logic [11:0] addr
	);
		mapped = addr_hit(addr, sps_pkg::ADDR_ACTIVE)
			|| addr_hit(addr, sps_pkg::ADDR_MIDDLE)
			|| addr_hit(addr, sps_pkg::ADDR_BOTTOM)
			|| addr_hit(addr, sps_pkg::ADDR_CONTROL)
			|| addr_hit(addr, sps_pkg::ADDR_EVENTS);
	endfunction

	// a write completes in the cycle after both halves are held and no response is pending
	assign wr_consume = aw_held && w_held && !s_reg.bvalid;

	// whole next-state of the bus slave and the control bits
	always_comb begin
		s_next        = s_reg;
		// entry write strobes are one-cycle pulses
		s_next.wr_top = 1'b0;
		s_next.wr_mid = 1'b0;
		s_next.wr_bot = 1'b0;

		// write response retires once the master takes it
		if (s_reg.bvalid && S_AXI_BREADY) begin
			s_next.bvalid = 1'b0;
		end

		// write: decode the held address, act on byte lane zero only
		if (wr_consume) begin
			s_next.bvalid  = 1'b1;
			s_next.bresp   = sps_pkg::RESP_OKAY;
			s_next.wr_data = w_word[7:0];
			if (!mapped(aw_addr)) begin
				s_next.bresp = sps_pkg::RESP_SLVERR;
			end else if (w_word[32]) begin
				// each entry has its own strobe
				s_next.wr_top = addr_hit(aw_addr, sps_pkg::ADDR_ACTIVE);
				s_next.wr_mid = addr_hit(aw_addr, sps_pkg::ADDR_MIDDLE);
				s_next.wr_bot = addr_hit(aw_addr, sps_pkg::ADDR_BOTTOM);
				if (addr_hit(aw_addr, sps_pkg::ADDR_CONTROL)) begin
					s_next.auto_en = w_word[sps_pkg::CTRL_AUTO_BIT];
				end
			end
		end

		// read: one request at a time, answered the next cycle
		if (s_reg.arready && S_AXI_ARVALID) begin
			s_next.arready = 1'b0;
			s_next.rvalid  = 1'b1;
			// a read samples the entries and changes nothing
			s_next.rdata   = read_word(S_AXI_ARADDR, page_top, page_mid,
				page_bot, s_reg.auto_en, s_reg.push_cnt, s_reg.pop_cnt);
			s_next.rresp   = mapped(S_AXI_ARADDR) ? sps_pkg::RESP_OKAY
				: sps_pkg::RESP_SLVERR;
		end else if (s_reg.rvalid && S_AXI_RREADY) begin
			s_next.rvalid  = 1'b0;
			s_next.arready = 1'b1;
		end

		// event counters wrap; they show what the stack really did
		if (push_ok) begin
			s_next.push_cnt = s_reg.push_cnt + 8'h01;
		end
		if (pop_ok) begin
			s_next.pop_cnt = s_reg.pop_cnt + 8'h01;
		end
	end

	// enable comes out of reset set
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			s_reg <= '{
				bvalid:   1'b0,
				bresp:    sps_pkg::RESP_OKAY,
				arready:  1'b1,
				rvalid:   1'b0,
				rresp:    sps_pkg::RESP_OKAY,
				rdata:    32'h0000_0000,
				auto_en:  sps_pkg::RST_AUTO_EN,
				wr_top:   1'b0,
				wr_mid:   1'b0,
				wr_bot:   1'b0,
				wr_data:  sps_pkg::RST_PAGE,
				push_cnt: sps_pkg::RST_COUNT,
				pop_cnt:  sps_pkg::RST_COUNT
			};
		end else begin
			s_reg <= s_next;
		end
	end

	// every output is a flop of this module, of the core or of a hold slot (AWREADY, WREADY)
	assign ACTIVE_PAGE_SELECT = page_top;
	assign AUTO_PAGE_ENABLE   = s_reg.auto_en;
	assign S_AXI_BVALID       = s_reg.bvalid;
	assign S_AXI_BRESP        = s_reg.bresp;
	assign S_AXI_ARREADY      = s_reg.arready;
	assign S_AXI_RVALID       = s_reg.rvalid;
	assign S_AXI_RRESP        = s_reg.rresp;
	assign S_AXI_RDATA        = s_reg.rdata;
endmodule
`default_nettype wire

// file: verilog/sps_pkg.sv
// constants for the page-context stack: register indexes, byte addresses,
// field positions, reset values and bus response codes.
// assumes a 32-bit axi4-lite register bus with a 12-bit byte address.
`default_nettype none
package sps_pkg;
	localparam int          PAGE_W    = 8;
	localparam int          DATA_W    = 32;
	localparam int          ADDR_W    = 12;
	localparam int          STACK_LVL = 3;

	// register indexes; byte address is four times the index
	localparam logic [7:0]  IDX_ACTIVE  = 8'h84;
	localparam logic [7:0]  IDX_MIDDLE  = 8'h85;
	localparam logic [7:0]  IDX_BOTTOM  = 8'h86;
	localparam logic [7:0]  IDX_CONTROL = 8'h96;
	localparam logic [7:0]  IDX_EVENTS  = 8'h97;

	localparam logic [11:0] ADDR_ACTIVE  = {2'h0, IDX_ACTIVE, 2'h0};
	localparam logic [11:0] ADDR_MIDDLE  = {2'h0, IDX_MIDDLE, 2'h0};
	localparam logic [11:0] ADDR_BOTTOM  = {2'h0, IDX_BOTTOM, 2'h0};
	localparam logic [11:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};
	localparam logic [11:0] ADDR_EVENTS  = {2'h0, IDX_EVENTS, 2'h0};

	// control register layout
	localparam int          CTRL_AUTO_BIT = 0;
	// event register layout: push count low byte, pop count next byte
	localparam int          EVT_PUSH_LSB = 0;
	localparam int          EVT_POP_LSB  = 8;

	// values after reset; EMPTY_PAGE fills the bottom on a pop
	localparam logic        RST_AUTO_EN  = 1'b1;
	localparam logic [7:0]  RST_PAGE     = 8'h00;
	localparam logic [7:0]  EMPTY_PAGE   = 8'h00;
	localparam logic [7:0]  RST_COUNT    = 8'h00;

	// axi response codes
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// file: verilog/sps_stack_core.sv
// three-level page stack: active page on top, middle and bottom below.
// assumes push and pop are single-cycle pulses from the cpu sequencer.
`timescale 1ns/1ns
`default_nettype none
module sps_stack_core (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       auto_en,
	input  wire logic       push,
	input  wire logic [7:0] push_page,
	input  wire logic       pop,
	input  wire logic       wr_top,
	input  wire logic       wr_mid,
	input  wire logic       wr_bot,
	input  wire logic [7:0] wr_data,
	output logic [7:0]      top_q,
	output logic [7:0]      mid_q,
	output logic [7:0]      bot_q
);
	typedef struct packed {
		logic [7:0] top;
		logic [7:0] mid;
		logic [7:0] bot;
	} sps_core_t;

	sps_core_t s_reg;
	sps_core_t s_next;

	// a cpu event wins over a software write in the same cycle
	always_comb begin
		s_next = s_reg;
		if (auto_en && push) begin
			s_next.bot = s_reg.mid;
			s_next.mid = s_reg.top;
			s_next.top = push_page;
		end else if (auto_en && pop) begin
			s_next.top = s_reg.mid;
			s_next.mid = s_reg.bot;
			s_next.bot = sps_pkg::EMPTY_PAGE;
		end else begin
			if (wr_top) begin
				s_next.top = wr_data;
			end
			if (wr_mid) begin
				s_next.mid = wr_data;
			end
			if (wr_bot) begin
				s_next.bot = wr_data;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_reg <= '{top: sps_pkg::RST_PAGE, mid: sps_pkg::RST_PAGE,
				bot: sps_pkg::RST_PAGE};
		end else begin
			s_reg <= s_next;
		end
	end

	assign top_q = s_reg.top;
	assign mid_q = s_reg.mid;
	assign bot_q = s_reg.bot;
endmodule
`default_nettype wire
